// >>> rtl/aip_defs.vh
// Constants for the audio input path control block: offsets, fields, timing.
// Assumes a 200 MHz system clock and byte-wide control registers.
// Operation
// - Any capture path routes to any converter channel
// - Source chosen per pair, routing per channel
// - Serial input forwards to serial output port
// - Playback input to converters gets 2.5 dB
// - Per-channel amp enable in registers 0x23-0x26
// - Precharge on at reset, disable, auto-off
// - Two bias outputs, enable and level each
// - Swap bit exchanges microphone left and right
// - Polarity bits invert microphone samples
// - Microphones sampled with our own clock output
// - Clock output disables second capture serial output
// - Microphone bits bypass ADC into shared filters
// - 24-bit samples at 192 or 96 kHz
// - Samples clip at full scale, never wrap
// - 0.375 dB attenuation steps down to -95.625 dB
// - Per-channel mute bits in 0x1B and 0x1C
// - Per-pair DC block, corner 1/4/8 Hz at 192 kHz, half that at 96 kHz
// - Serial input goes to DAC or serial out
// - Per-side headphone or line driver select
`ifndef AIP_DEFS_VH
`define AIP_DEFS_VH
// Register offsets
`define AIP_ADC_CTRL_A 8'h1B
`define AIP_ADC_CTRL_B 8'h1C
`define AIP_ADC_CTRL_C 8'h1D
`define AIP_ADC_CTRL_D 8'h1E
`define AIP_ATTEN_CH0 8'h1F
`define AIP_ATTEN_CH3 8'h22
`define AIP_AMP_CH0 8'h23
`define AIP_AMP_CH3 8'h26
`define AIP_PRECHARGE 8'h29
`define AIP_MIC_BIAS 8'h2D
`define AIP_PINMODE_A 8'h3C
`define AIP_PINMODE_B 8'h3D
`define AIP_RC_ROUTE 8'h40
`define AIP_SER_ROUTE 8'h41
`define AIP_DRV_SEL 8'h43
// Field positions and codes
`define AIP_RATE96_BIT 2
`define AIP_DC_EN_BIT 2
`define AIP_PINMODE_PDM 4'h2
`define AIP_CLOCK_OUT_PIN_BIT 6
`define AIP_FWD_BIT 5
`define AIP_RESET_VAL 8'h00
`define AIP_ROUTE_RST 8'hE4
// Timing
`define AIP_CLK_HZ 200000000
`define AIP_FS_HI_HZ 192000
`define AIP_DIV_HI (`AIP_CLK_HZ / `AIP_FS_HI_HZ)
`define AIP_DIV_LO (2 * `AIP_DIV_HI)
`define AIP_PDM_HALF 32
`define AIP_HP_WAIT_MS 6
`define AIP_HP_WAIT_CYC (`AIP_HP_WAIT_MS * (`AIP_CLK_HZ / 1000))
`define AIP_PB_GAIN_Q15 16'hAAB0
`endif

// >>> rtl/aip_top.v
// Audio input path control: registers, microphone capture, volume, routing.
// Assumes capture samples, playback words and register strobes share clk;
// microphone data pins arrive unsynchronised.
`include "aip_defs.vh"
module aip_top #(
  parameter HP_WAIT_CYC = `AIP_HP_WAIT_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control register port
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Analog converter samples
  input wire [23:0] adc_in_0,
  input wire [23:0] adc_in_1,
  input wire [23:0] adc_in_2,
  input wire [23:0] adc_in_3,
  // Microphone pins
  input wire pdm_data_pin_a,
  input wire pdm_data_pin_b,
  output wire clock_out_pin,
  // Serial ports
  input wire [23:0] playback_serial_in_l,
  input wire [23:0] playback_serial_in_r,
  input wire playback_serial_in_valid,
  input wire capture_serial_out_b_int,
  output wire capture_serial_out_b,
  output reg [23:0] dac_l,
  output reg [23:0] dac_r,
  output reg dac_valid,
  output reg [23:0] fwd_l,
  output reg [23:0] fwd_r,
  output reg fwd_valid,
  // Rate converter feed
  output reg [95:0] rc_data,
  output reg rc_valid,
  // Analog controls
  output wire [3:0] input_amp_enable,
  output wire [3:0] precharge_in_on,
  output wire [1:0] precharge_hp_on,
  output wire bias_output_a,
  output wire bias_a_high,
  output wire bias_output_b,
  output wire bias_b_high,
  output wire phones_drive_left,
  output wire phones_drive_right
);

  reg [7:0] ctrl_a_r, ctrl_b_r, ctrl_c_r, ctrl_d_r;
  reg [7:0] atten_r [0:3];
  reg [7:0] amp_r [0:3];
  reg [7:0] prech_r, bias_r, pin_a_r, pin_b_r, route_r, ser_r, drv_r;
  wire [1:0] hp_ready_r;
  integer i, j;

  // Register writes; reserved bits are kept at zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_r <= `AIP_RESET_VAL;
      ctrl_b_r <= `AIP_RESET_VAL;
      ctrl_c_r <= `AIP_RESET_VAL;
      ctrl_d_r <= `AIP_RESET_VAL;
      prech_r <= `AIP_RESET_VAL;
      bias_r <= `AIP_RESET_VAL;
      pin_a_r <= `AIP_RESET_VAL;
      pin_b_r <= `AIP_RESET_VAL;
      route_r <= `AIP_ROUTE_RST;
      ser_r <= `AIP_RESET_VAL;
      drv_r <= `AIP_RESET_VAL;
      for (i = 0; i < 4; i = i + 1) begin
        atten_r[i] <= `AIP_RESET_VAL;
        amp_r[i] <= `AIP_RESET_VAL;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `AIP_ADC_CTRL_A: ctrl_a_r <= reg_wdata & 8'h07;
        `AIP_ADC_CTRL_B: ctrl_b_r <= reg_wdata & 8'h03;
        `AIP_ADC_CTRL_C: ctrl_c_r <= reg_wdata & 8'h7F;
        `AIP_ADC_CTRL_D: ctrl_d_r <= reg_wdata & 8'h7F;
        `AIP_PRECHARGE: prech_r <= reg_wdata & 8'h3F;
        `AIP_MIC_BIAS: bias_r <= reg_wdata & 8'h0F;
        `AIP_PINMODE_A: pin_a_r <= reg_wdata & 8'h0F;
        `AIP_PINMODE_B: pin_b_r <= reg_wdata & 8'h0F;
        `AIP_RC_ROUTE: route_r <= reg_wdata;
        `AIP_SER_ROUTE: ser_r <= reg_wdata & 8'h6F;
        `AIP_DRV_SEL: drv_r <= reg_wdata & 8'h03;
        default: begin
          if (reg_addr >= `AIP_ATTEN_CH0 && reg_addr <= `AIP_ATTEN_CH3) begin
            atten_r[reg_addr[1:0] - 2'd3] <= reg_wdata;
          end
          if (reg_addr >= `AIP_AMP_CH0 && reg_addr <= `AIP_AMP_CH3) begin
            amp_r[reg_addr[1:0] - 2'd3] <= reg_wdata & 8'h01;
          end
        end
      endcase
    end
  end

  // Readback; unmapped offsets read zero, drive select shows ready bits
  always @* begin
    case (reg_addr)
      `AIP_ADC_CTRL_A: reg_rdata = ctrl_a_r;
      `AIP_ADC_CTRL_B: reg_rdata = ctrl_b_r;
      `AIP_ADC_CTRL_C: reg_rdata = ctrl_c_r;
      `AIP_ADC_CTRL_D: reg_rdata = ctrl_d_r;
      `AIP_PRECHARGE: reg_rdata = prech_r;
      `AIP_MIC_BIAS: reg_rdata = bias_r;
      `AIP_PINMODE_A: reg_rdata = pin_a_r;
      `AIP_PINMODE_B: reg_rdata = pin_b_r;
      `AIP_RC_ROUTE: reg_rdata = route_r;
      `AIP_SER_ROUTE: reg_rdata = ser_r;
      `AIP_DRV_SEL: reg_rdata = {4'h0, hp_ready_r, drv_r[1:0]};
      default: begin
        if (reg_addr >= `AIP_ATTEN_CH0 && reg_addr <= `AIP_ATTEN_CH3)
          reg_rdata = atten_r[reg_addr[1:0] - 2'd3];
        else if (reg_addr >= `AIP_AMP_CH0 && reg_addr <= `AIP_AMP_CH3)
          reg_rdata = amp_r[reg_addr[1:0] - 2'd3];
        else
          reg_rdata = 8'h00;
      end
    endcase
  end

  // Analog side controls
  assign input_amp_enable = {amp_r[3][0], amp_r[2][0], amp_r[1][0], amp_r[0][0]};
  // Precharge runs from reset until disabled or its amplifier comes up
  assign precharge_in_on = ~prech_r[3:0] & ~input_amp_enable;
  assign precharge_hp_on = ~prech_r[5:4] & ~drv_r[1:0];
  assign bias_output_a = bias_r[0];
  assign bias_a_high = bias_r[1];
  assign bias_output_b = bias_r[2];
  assign bias_b_high = bias_r[3];
  assign phones_drive_left = drv_r[0];
  assign phones_drive_right = drv_r[1];

  // Headphone settle timers; informational only, unmute stays the host's job
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_hp
      reg [20:0] cnt_r;
      reg rdy_r;
      assign hp_ready_r[g] = rdy_r;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r <= 21'h00_0000;
          rdy_r <= 1'b0;
        end else if (!drv_r[g]) begin
          cnt_r <= 21'h00_0000;
          rdy_r <= 1'b0;
        end else if (cnt_r >= HP_WAIT_CYC[20:0] - 21'd1) begin
          rdy_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 21'd1;
        end
      end
    end
  endgenerate

  // Sample rate strobe from a divider of clk
  wire rate96 = ctrl_a_r[`AIP_RATE96_BIT];
  reg [11:0] fs_cnt_r;
  reg fs_stb_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_cnt_r <= 12'h000;
      fs_stb_r <= 1'b0;
    end else begin
      fs_stb_r <= 1'b0;
      if (fs_cnt_r >= (rate96 ? `AIP_DIV_LO : `AIP_DIV_HI) - 1) begin
        fs_cnt_r <= 12'h000;
        fs_stb_r <= 1'b1;
      end else begin
        fs_cnt_r <= fs_cnt_r + 12'd1;
      end
    end
  end

  // Microphone clock: divided from clk, free-running; the pin is gated by the clock select bit only
  wire [1:0] pdm_on;
  assign pdm_on[0] = ctrl_c_r[0] && pin_a_r[3:0] == `AIP_PINMODE_PDM;
  assign pdm_on[1] = ctrl_d_r[0] && pin_b_r[3:0] == `AIP_PINMODE_PDM;
  reg [5:0] half_cnt_r;
  reg pdm_clk_r;
  reg rise_r, fall_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 6'h00;
      pdm_clk_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      if (half_cnt_r == `AIP_PDM_HALF - 1) begin
        half_cnt_r <= 6'h00;
        pdm_clk_r <= ~pdm_clk_r;
        // Sample just before the next toggle, data has had a half period
        rise_r <= pdm_clk_r;
        fall_r <= ~pdm_clk_r;
      end else begin
        half_cnt_r <= half_cnt_r + 6'd1;
      end
    end
  end

  // Shared pin: clock output replaces the second capture serial output
  wire clk_sel = ser_r[`AIP_CLOCK_OUT_PIN_BIT];
  assign clock_out_pin = clk_sel & pdm_clk_r;
  assign capture_serial_out_b = clk_sel ? 1'b0 : capture_serial_out_b_int;

  // Two-flop synchronisers on the data pins
  reg [1:0] pin_m_r, pin_s_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_m_r <= 2'b00;
      pin_s_r <= 2'b00;
    end else begin
      pin_m_r <= {pdm_data_pin_b, pdm_data_pin_a};
      pin_s_r <= pin_m_r;
    end
  end

  // Density accumulators, lane 0 on high phase end, lane 1 on low phase end
  wire [31:0] snap_w;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_acc
      wire hit = (g % 2 == 0) ? rise_r : fall_r;
      wire bit_in = pin_s_r[g / 2];
      reg signed [7:0] acc_r, snap_r;
      assign snap_w[g * 8 +: 8] = snap_r;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          acc_r <= 8'sh00;
          snap_r <= 8'sh00;
        end else if (fs_stb_r) begin
          snap_r <= acc_r;
          acc_r <= 8'sh00;
        end else if (hit && pdm_on[g / 2] && clk_sel) begin
          acc_r <= bit_in ? acc_r + 8'sd1 : acc_r - 8'sd1;
        end
      end
    end
  endgenerate

  // Clip to 24 bits instead of wrapping
  function [23:0] sat24;
    input signed [47:0] v;
    begin
      if (v > 48'sh0000_007F_FFFF)
        sat24 = 24'h7F_FFFF;
      else if (v < -48'sh0000_0080_0000)
        sat24 = 24'h80_0000;
      else
        sat24 = v[23:0];
    end
  endfunction

  // Fractional part of one attenuation step set, unity is 2^15
  function [15:0] step_gain;
    input [3:0] k;
    begin
      case (k)
        4'd0: step_gain = 16'h8000;
        4'd1: step_gain = 16'h7A97;
        4'd2: step_gain = 16'h7569;
        4'd3: step_gain = 16'h7073;
        4'd4: step_gain = 16'h6BB2;
        4'd5: step_gain = 16'h6725;
        4'd6: step_gain = 16'h62C9;
        4'd7: step_gain = 16'h5E9C;
        4'd8: step_gain = 16'h5A9D;
        4'd9: step_gain = 16'h56C9;
        4'd10: step_gain = 16'h531E;
        4'd11: step_gain = 16'h4F9B;
        4'd12: step_gain = 16'h4C3E;
        4'd13: step_gain = 16'h4905;
        4'd14: step_gain = 16'h45EF;
        default: step_gain = 16'h42FA;
      endcase
    end
  endfunction

  // Per-channel capture path: source, DC block, volume, mute
  wire [95:0] adc_bus = {adc_in_3, adc_in_2, adc_in_1, adc_in_0};
  wire [15:0] pair_c = {ctrl_d_r, ctrl_c_r};
  wire [3:0] mute = {ctrl_b_r[1:0], ctrl_a_r[1:0]};
  reg [3:0] stb_d_r;
  wire [95:0] cap_r;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      wire [7:0] pc = pair_c[(g / 2) * 8 +: 8];
      wire lane = (g % 2 == 1) ^ pc[1];
      wire signed [7:0] d_raw = snap_w[((g / 2) * 2 + lane) * 8 +: 8];
      wire signed [7:0] d_pol = pc[5 + g % 2] ? -d_raw : d_raw;
      wire signed [47:0] d_scl = rate96 ? ({{40{d_pol[7]}}, d_pol} <<< 17)
                                        : ({{40{d_pol[7]}}, d_pol} <<< 18);
      reg signed [23:0] x_r, y_r;
      reg signed [39:0] dc_r;
      reg signed [41:0] prod_r;
      reg [23:0] cap_g_r;
      assign cap_r[g * 24 +: 24] = cap_g_r;
      wire [4:0] hp_k = (pc[4:3] == 2'd0) ? 5'd15 : (pc[4:3] == 2'd1) ? 5'd13 : 5'd12;
      wire signed [24:0] y_full = {x_r[23], x_r} - {dc_r[39], dc_r[39:16]};
      wire signed [47:0] y_ext = {{23{y_full[24]}}, y_full};
      wire signed [39:0] y_up = {y_r, 16'h0000};
      wire signed [47:0] vol_v = $signed({{6{prod_r[41]}}, prod_r}) >>> (15 + atten_r[g][7:4]);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          x_r <= 24'sh00_0000;
          y_r <= 24'sh00_0000;
          dc_r <= 40'sh00_0000_0000;
          prod_r <= 42'sh000_0000_0000;
          cap_g_r <= 24'h00_0000;
        end else begin
          if (fs_stb_r) begin
            // Microphone bits feed the shared filter in place of the ADC
            x_r <= pdm_on[g / 2] ? sat24(d_scl) : adc_bus[g * 24 +: 24];
          end
          if (stb_d_r[0]) begin
            y_r <= pc[`AIP_DC_EN_BIT] ? sat24(y_ext) : x_r;
          end
          if (stb_d_r[1]) begin
            // Leaky tracker of the DC level, corner set by the shift
            dc_r <= pc[`AIP_DC_EN_BIT] ? dc_r + (y_up >>> hp_k) : 40'sh00_0000_0000;
            prod_r <= y_r * $signed({2'b00, step_gain(atten_r[g][3:0])});
          end
          if (stb_d_r[2]) begin
            cap_g_r <= mute[g] ? 24'h00_0000 : sat24(vol_v);
          end
        end
      end
    end
  endgenerate

  // Strobe pipeline
  always @(posedge clk or posedge rst) begin
    if (rst)
      stb_d_r <= 4'h0;
    else
      stb_d_r <= {stb_d_r[2:0], fs_stb_r};
  end

  // Playback words with the converter path gain applied
  wire signed [47:0] pb_l = $signed(playback_serial_in_l) * $signed({8'h00, `AIP_PB_GAIN_Q15});
  wire signed [47:0] pb_r = $signed(playback_serial_in_r) * $signed({8'h00, `AIP_PB_GAIN_Q15});
  reg [23:0] pbg_l_r, pbg_r_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pbg_l_r <= 24'h00_0000;
      pbg_r_r <= 24'h00_0000;
      dac_l <= 24'h00_0000;
      dac_r <= 24'h00_0000;
      dac_valid <= 1'b0;
      fwd_l <= 24'h00_0000;
      fwd_r <= 24'h00_0000;
      fwd_valid <= 1'b0;
    end else begin
      dac_valid <= 1'b0;
      fwd_valid <= 1'b0;
      if (playback_serial_in_valid) begin
        pbg_l_r <= sat24(pb_l >>> 15);
        pbg_r_r <= sat24(pb_r >>> 15);
        if (ser_r[`AIP_FWD_BIT]) begin
          // Chained device data continues onto the serial output
          fwd_l <= playback_serial_in_l;
          fwd_r <= playback_serial_in_r;
          fwd_valid <= 1'b1;
        end else begin
          dac_l <= playback_serial_in_l;
          dac_r <= playback_serial_in_r;
          dac_valid <= 1'b1;
        end
      end
    end
  end

  // Converter feed: each slot picks any capture path or playback
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_data <= 96'h0;
      rc_valid <= 1'b0;
    end else begin
      rc_valid <= stb_d_r[3];
      if (stb_d_r[3]) begin
        for (j = 0; j < 4; j = j + 1) begin
          if (ser_r[j])
            rc_data[j * 24 +: 24] <= (j % 2 == 0) ? pbg_l_r : pbg_r_r;
          else
            rc_data[j * 24 +: 24] <= cap_r[route_r[j * 2 +: 2] * 24 +: 24];
        end
      end
    end
  end

endmodule

// >>> verif/aip_top_properties.sv
// Concurrent checks on the ports of aip_top, bound in from the bench.
// Assumes one clock domain on clk with asynchronous active-high rst.
`include "aip_defs.vh"
module aip_top_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Inputs that cause outputs
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [23:0] playback_serial_in_l,
  input wire playback_serial_in_valid,
  // Outputs under watch
  input wire [23:0] dac_l,
  input wire dac_valid,
  input wire [23:0] fwd_l,
  input wire fwd_valid,
  input wire [95:0] rc_data,
  input wire rc_valid,
  input wire clock_out_pin,
  input wire capture_serial_out_b,
  input wire [3:0] input_amp_enable,
  input wire [3:0] precharge_in_on,
  input wire bias_output_a,
  input wire phones_drive_left
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Cycles since the last sample; saturates so a long idle never wraps
  logic [11:0] gap_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= 12'hfff;
    end else if (rc_valid) begin
      gap_r <= 12'h000;
    end else if (gap_r != 12'hfff) begin
      gap_r <= gap_r + 12'h001;
    end
  end
  // A word is taken, then shows on exactly one of the two playback outputs
  sequence s_pb_taken;
    playback_serial_in_valid;
  endsequence
  sequence s_pb_shown;
    (dac_valid && !fwd_valid && dac_l == $past(playback_serial_in_l)) ||
    (fwd_valid && !dac_valid && fwd_l == $past(playback_serial_in_l));
  endsequence
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  AST_PB_ROUTE: assert property (s_pb_taken |=> s_pb_shown)
    else $error("playback word not shown once");
  AST_PB_IDLE: assert property (!playback_serial_in_valid |=> !dac_valid && !fwd_valid)
    else $error("playback output without a word");
  AST_RC_HOLD: assert property (!rc_valid |-> $stable(rc_data))
    else $error("converter data moved without a sample");
  AST_RC_SPACING: assert property (rc_valid |-> gap_r >= 12'd1040)
    else $error("capture samples too close");
  AST_AMP_PRECH: assert property ((input_amp_enable & precharge_in_on) == 4'h0)
    else $error("precharge on beside an enabled amp");
  AST_AMP_WR: assert property (s_wr(`AIP_AMP_CH0) |=> input_amp_enable[0] == $past(reg_wdata[0]))
    else $error("amp enable not taken");
  AST_BIAS_WR: assert property (s_wr(`AIP_MIC_BIAS) |=> bias_output_a == $past(reg_wdata[0]))
    else $error("bias enable not taken");
  AST_DRV_WR: assert property (s_wr(`AIP_DRV_SEL) |=> phones_drive_left == $past(reg_wdata[0]))
    else $error("driver select not taken");
  AST_CLK_HALF: assert property ($rose(clock_out_pin) |-> ##32 !clock_out_pin)
    else $error("mic clock high phase too long");
  AST_CLK_MUX: assert property (clock_out_pin |-> !capture_serial_out_b)
    else $error("serial output live beside mic clock");
endmodule

// >>> verif/aip_mic_model.sv
// Two microphones on each data pin, clocked only by the device clock pin.
// Assumes the clock pin rests low when the device is not capturing.
module aip_mic_model #(
  parameter realtime DLY = 3.0
) (
  // Clock from the device
  input wire clock_out_pin,
  // Data back to the device
  output logic pdm_data_pin_a,
  output logic pdm_data_pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime last_edge = 0.0;
  initial pdm_data_pin_a = 1'b0;
  initial pdm_data_pin_b = 1'b0;
  // Left mic sends ones in the high phase, right mic zeros in the low phase
  always @(clock_out_pin) begin
    last_edge = $realtime;
    #(DLY) pdm_data_pin_a = clock_out_pin;
    pdm_data_pin_b = clock_out_pin;
  end
  // No clock means released lines; toggling keeps stale data from looking valid
  always #20 if ($realtime - last_edge > 200.0) begin
    pdm_data_pin_a = ~pdm_data_pin_a;
    pdm_data_pin_b = ~pdm_data_pin_b;
  end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for aip_top: registers, capture, playback, microphones.
// Assumes the microphone model on the far side and a short headphone wait.
`include "aip_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT = 50;
  logic clk = 0, rst = 1, reg_wr = 0, playback_serial_in_valid = 0;
  logic capture_serial_out_b_int = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, route;
  logic [23:0] adc[4] = '{default: 0};
  logic [23:0] playback_serial_in_l = 0, playback_serial_in_r = 0;
  logic [23:0] dac_l, dac_r, fwd_l, fwd_r;
  logic [95:0] rc_data;
  logic [7:0] atten[4];
  logic [3:0] mute, input_amp_enable, precharge_in_on;
  logic [1:0] precharge_hp_on;
  logic dac_valid, fwd_valid, rc_valid, clock_out_pin, capture_serial_out_b;
  logic bias_output_a, bias_a_high, bias_output_b, bias_b_high;
  logic phones_drive_left, phones_drive_right, pdm_data_pin_a, pdm_data_pin_b;
  logic [31:0] seed = 32'h0000_e1e5;
  int n_fail = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  aip_top #(.HP_WAIT_CYC(WAIT)) dut (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .adc_in_0(adc[0]), .adc_in_1(adc[1]), .adc_in_2(adc[2]), .adc_in_3(adc[3]),
    .pdm_data_pin_a, .pdm_data_pin_b, .clock_out_pin, .playback_serial_in_l,
    .playback_serial_in_r, .playback_serial_in_valid, .capture_serial_out_b_int,
    .capture_serial_out_b, .dac_l, .dac_r, .dac_valid, .fwd_l, .fwd_r, .fwd_valid, .rc_data,
    .rc_valid, .input_amp_enable, .precharge_in_on, .precharge_hp_on, .bias_output_a,
    .bias_a_high, .bias_output_b, .bias_b_high, .phones_drive_left, .phones_drive_right);
  aip_mic_model mics (.clock_out_pin, .pdm_data_pin_a, .pdm_data_pin_b);
  // Random source: shift register, fixed start
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Expected converter slot: routed path, then attenuation and mute
  function automatic logic [23:0] exp_slot(input int i);
    int p;
    p = route[2*i+:2];
    if (mute[p]) return 24'h00_0000;
    return $signed(adc[p]) >>> atten[p][7:4];
  endfunction
  // Playback copy for the converters with its extra gain, positive values only
  function automatic logic [23:0] pb_gain(input logic [47:0] v);
    return 24'((v * `AIP_PB_GAIN_Q15) >> 15);
  endfunction
  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Byte write: strobe high for one edge, inputs move on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    #1;
    chk("reg", reg_rdata, exp);
  endtask
  // Bounded wait for n fresh capture samples
  task automatic wait_rc(input int n);
    int i;
    repeat (n) begin
      for (i = 0; i < 3000 && rc_valid !== 1'b1; i++) @(negedge clk);
      chk("rc_wait", i < 3000, 1'b1);
      @(negedge clk);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    int i, k, t;
    logic [7:0] r;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk("prech_in", precharge_in_on, 4'hf);
    chk("prech_hp", precharge_hp_on, 2'h3);
    rdc(`AIP_RC_ROUTE, 8'he4);
    rdc(8'h50, 8'h00);
    // Each amp enable drops only its own input precharge
    for (i = 0; i < 4; i++) begin
      wr(8'(`AIP_AMP_CH0 + i), 8'h01);
      chk("amp_en", input_amp_enable, (4'h2 << i) - 4'h1);
      chk("prech_in", precharge_in_on, 4'(4'hf << (i + 1)));
    end
    wr(`AIP_PRECHARGE, 8'h30);
    chk("prech_hp", precharge_hp_on, 2'h0);
    wr(`AIP_PRECHARGE, 8'h00);
    r = 8'(rnd());
    wr(`AIP_MIC_BIAS, r);
    chk("bias", {bias_b_high, bias_output_b, bias_a_high, bias_output_a}, r[3:0]);
    rdc(`AIP_MIC_BIAS, {4'h0, r[3:0]});
    // Headphone drivers: ready bits only after the wait has run
    wr(`AIP_DRV_SEL, 8'h03);
    chk("drv", {phones_drive_right, phones_drive_left}, 2'h3);
    chk("prech_hp", precharge_hp_on, 2'h0);
    rdc(`AIP_DRV_SEL, 8'h03);
    repeat (WAIT + 4) @(negedge clk);
    rdc(`AIP_DRV_SEL, 8'h0f);
    wr(`AIP_DRV_SEL, 8'h00);
    chk("drv", {phones_drive_right, phones_drive_left}, 2'h0);
    capture_serial_out_b_int = 1;
    #1;
    chk("ser_b", capture_serial_out_b, 1'b1);
    wr(`AIP_SER_ROUTE, 8'h40);
    chk("ser_b", capture_serial_out_b, 1'b0);
    // Pair enabled but pin mode not set: the ADC still feeds the path
    adc[0] = 24'(rnd());
    wr(`AIP_ADC_CTRL_C, 8'h01);
    wait_rc(2);
    chk("slot0", rc_data[23:0], adc[0]);
    // A steady input through the DC block must start to fall away
    adc[0] = 24'h40_0000;
    wr(`AIP_ADC_CTRL_C, 8'h15);
    wait_rc(3);
    chk("dc_block", rc_data[23:0] < 24'h40_0000 && rc_data[23:0] > 24'h3F_0000, 1'b1);
    wr(`AIP_ADC_CTRL_C, 8'h01);
    wr(`AIP_PINMODE_A, {4'h0, `AIP_PINMODE_PDM});
    wr(`AIP_PINMODE_B, {4'h0, `AIP_PINMODE_PDM});
    wr(`AIP_ADC_CTRL_D, 8'h01);
    // Counts need one whole window after the enable, then one more sample
    wait_rc(4);
    chk("mic_sign", {rc_data[95], rc_data[71], rc_data[47], rc_data[23]}, 4'ha);
    wr(`AIP_ADC_CTRL_C, 8'h03);
    wr(`AIP_ADC_CTRL_D, 8'h21);
    wait_rc(2);
    chk("mic_sign", {rc_data[95], rc_data[71], rc_data[47], rc_data[23]}, 4'hd);
    wr(`AIP_ADC_CTRL_C, 8'h41);
    wr(`AIP_ADC_CTRL_D, 8'h01);
    wait_rc(2);
    chk("mic_sign", {rc_data[95], rc_data[71], rc_data[47], rc_data[23]}, 4'h8);
    wr(`AIP_ADC_CTRL_C, 8'h00);
    wr(`AIP_ADC_CTRL_D, 8'h00);
    wr(`AIP_SER_ROUTE, 8'h00);
    // Sample spacing at both rates
    for (k = 0; k < 2; k++) begin
      wr(`AIP_ADC_CTRL_A, k ? 8'h00 : 8'h04);
      wait_rc(2);
      for (t = 1; t < 3000 && rc_valid !== 1'b1; t++) @(negedge clk);
      chk("gap", t, k ? 1041 : 2082);
    end
    // Routing, attenuation and mute; first passes are the corner cases
    for (k = 0; k < 5; k++) begin
      route = k == 0 ? 8'he4 : 8'(rnd());
      mute = k < 2 ? 4'h0 : 4'(rnd());
      wr(`AIP_RC_ROUTE, route);
      wr(`AIP_ADC_CTRL_A, {6'h00, mute[1:0]});
      wr(`AIP_ADC_CTRL_B, {6'h00, mute[3:2]});
      for (i = 0; i < 4; i++) begin
        adc[i] = 24'(rnd());
        atten[i] = k == 1 ? 8'hf0 : k == 0 ? 8'h00 : {4'(rnd() % 3), 4'h0};
        wr(8'(`AIP_ATTEN_CH0 + i), atten[i]);
      end
      wait_rc(2);
      for (i = 0; i < 4; i++) chk("slot", rc_data[24*i+:24], exp_slot(i));
    end
    // Playback alternates between the DAC and the serial output
    for (k = 0; k < 6; k++) begin
      wr(`AIP_SER_ROUTE, k[0] ? 8'h20 : 8'h00);
      @(negedge clk);
      playback_serial_in_l = 24'(rnd());
      playback_serial_in_r = 24'(rnd());
      playback_serial_in_valid = 1;
      @(negedge clk);
      playback_serial_in_valid = 0;
      chk("pb_l", k[0] ? fwd_l : dac_l, playback_serial_in_l);
      chk("pb_r", k[0] ? fwd_r : dac_r, playback_serial_in_r);
      chk("pb_v", {fwd_valid, dac_valid}, k[0] ? 2'h2 : 2'h1);
    end
    wr(`AIP_SER_ROUTE, 8'h03);
    @(negedge clk);
    playback_serial_in_l = 24'h01_0000;
    playback_serial_in_r = 24'h7F_FFFF;
    playback_serial_in_valid = 1;
    @(negedge clk);
    playback_serial_in_valid = 0;
    wait_rc(2);
    chk("pb_gain", rc_data[23:0], pb_gain(48'h0000_0001_0000));
    chk("pb_clip", rc_data[47:24], 24'h7F_FFFF);
    complete_run();
  end
  // Watchdog: 80k cycles, about twice the expected run of about 35k cycles
  initial begin
    #400_000;
    n_fail++;
    complete_run();
  end
endmodule
bind aip_top aip_top_properties u_props (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
  .playback_serial_in_l, .playback_serial_in_valid, .dac_l, .dac_valid, .fwd_l, .fwd_valid,
  .rc_data, .rc_valid, .clock_out_pin, .capture_serial_out_b, .input_amp_enable,
  .precharge_in_on, .bias_output_a, .phones_drive_left);
